// ===== bench/osc_link_monitor.sv
// Purpose: Link checks between host and converter control
// Assumes: One clock, reset async active low
// Notes:   Busy length is counted in helper logic; only the minimum check uses repetition
`timescale 1ns/1ps
module osc_link_monitor
    import osc_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       conversion_start_group_a,
    input wire logic       conversion_start_group_b,
    input wire logic [2:0] oversample_ratio_select,
    input wire logic       busy,
    input wire logic       read_strobe
);
    logic [16:0] busy_cnt_q;
    logic [2:0]  run_ratio_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Busy-high cycle count; cleared while low so each conversion starts at zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_q <= 17'h0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 17'h1 : 17'h0;
        end
    end
    // Ratio in force for the conversion that the start edge opens
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run_ratio_q <= 3'h0;
        end else if (conversion_start_group_a && !busy) begin
            run_ratio_q <= oversample_ratio_select;
        end
    end
    property p_start_paired; conversion_start_group_a == conversion_start_group_b; endproperty
    a_start_paired: assert property (p_start_paired) else $error("start lines split");
    property p_busy_answer; $rose(conversion_start_group_a) && !busy |-> ##[3:4] busy; endproperty
    a_busy_answer: assert property (p_busy_answer) else $error("busy late");
    property p_busy_len; $fell(busy) |-> busy_cnt_q == (1 << run_ratio_q) * OSC_CONV_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_min; $rose(busy) |-> busy[*8]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    property p_busy_max; busy |-> busy_cnt_q <= 64 * OSC_CONV_CYCLES + 1; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_no_start_busy; $rose(conversion_start_group_a) |-> !busy; endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
    property p_read_pulse; $rose(read_strobe) |-> ##1 read_strobe ##1 !read_strobe; endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read strobe shape");
    property p_ratio_legal; oversample_ratio_select != 3'h7; endproperty
    a_ratio_legal: assert property (p_ratio_legal) else $error("ratio code 7");
endmodule : osc_link_monitor

// ===== bench/oversampling_conversion_control_tb.sv
// Purpose: Host and converter joined back to back, results checked at user ports
// Assumes: Full conversion time of the package; ratios 32 and 64 skipped to keep the run short
// Notes:   Samples change only mid-way between takes so either take edge sees one value
`timescale 1ns/1ps
module oversampling_conversion_control_tb
    import osc_pkg::*;
;
    logic                                 ref_clk, rstn, sample_take_q, start_mismatch_q;
    logic                                 start_req, read_req, read_valid_q, fix;
    logic [2:0]                           ratio_req, read_chan_req;
    logic [OSC_CHANNELS*OSC_SAMPLE_W-1:0] analog_sample;
    logic [127:0]                         rnd;
    osc_sample_type                       read_value_q, prev [OSC_CHANNELS];
    longint                               sum [OSC_CHANNELS];
    int                                   error_cnt, n_tests, n_samp, busy_len, gap;
    int                                   ratios [6] = '{0, 1, 2, 3, 4, 1};
    osc_link_if link_inst ();
    osc_device osc_device_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link_inst.device),
        .analog_sample(analog_sample), .sample_take_q(sample_take_q),
        .start_mismatch_q(start_mismatch_q));
    osc_host osc_host_inst (.ref_clk(ref_clk), .rstn(rstn), .link(link_inst.host),
        .start_req(start_req), .ratio_req(ratio_req), .read_req(read_req),
        .read_chan_req(read_chan_req), .start_q(), .ratio_q(), .read_q(), .read_chan_q(),
        .read_value_q(read_value_q), .read_valid_q(read_valid_q), .busy_seen_q());
    osc_link_monitor osc_link_monitor_inst (.ref_clk(ref_clk), .rstn(rstn),
        .conversion_start_group_a(link_inst.conversion_start_group_a),
        .conversion_start_group_b(link_inst.conversion_start_group_b),
        .oversample_ratio_select(link_inst.oversample_ratio_select),
        .busy(link_inst.busy), .read_strobe(link_inst.read_strobe));
    // 250 MHz clock
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    function automatic osc_sample_type exp_avg(input longint s, input int r);
        return osc_sample_type'(s >>> r);
    endfunction : exp_avg
    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // One read; entered at a falling edge, bounded wait for the valid pulse
    task automatic rd(input int c, output osc_sample_type v);
        int k;
        read_chan_req = 3'(c);
        read_req = 1'b1;
        @(negedge ref_clk);
        read_req = 1'b0;
        for (k = 0; k < 30 && read_valid_q !== 1'b1; k++) @(negedge ref_clk);
        check(k < 30, 1'b1);
        v = read_value_q;
        @(negedge ref_clk);
    endtask : rd
    // Records each take; busy counted per cycle for the length check
    always @(negedge ref_clk) begin
        gap++;
        if (link_inst.busy === 1'b1) busy_len++;
        if (sample_take_q === 1'b1) begin
            n_samp++;
            gap = 0;
            for (int c = 0; c < OSC_CHANNELS; c++)
                sum[c] += $signed(analog_sample[c*OSC_SAMPLE_W +: OSC_SAMPLE_W]);
        end
        if (gap == 500 && !fix) begin
            rnd = {$urandom, $urandom, $urandom, $urandom};
            analog_sample = rnd[OSC_CHANNELS*OSC_SAMPLE_W-1:0];
        end
    end
    // One conversion at ratios[i]; previous results read back while busy is high
    task automatic run_conv(input int i);
        osc_sample_type v;
        int k;
        int r;
        r = ratios[i];
        if (i == 5) begin
            fix = 1'b1;
            analog_sample = {4{14'h1fff, 14'h2000}}; // Full scale of both signs
        end
        repeat (2 + $urandom_range(0, 6)) @(negedge ref_clk); // Start only once idle
        n_samp = 0;
        busy_len = 0;
        for (k = 0; k < OSC_CHANNELS; k++) sum[k] = 0;
        start_req = 1'b1;
        @(negedge ref_clk);
        start_req = 1'b0;
        for (k = 0; k < 10 && link_inst.busy !== 1'b1; k++) @(negedge ref_clk);
        for (k = 0; k < OSC_CHANNELS && i > 0; k++) begin
            rd(k, v);
            check(v, prev[k]);
        end
        // Next ratio changes mid-conversion; it must wait for the busy fall
        ratio_req = 3'(ratios[(i + 1) % 6]);
        for (k = 0; k < 70000 && link_inst.busy !== 1'b0; k++) @(negedge ref_clk);
        check(busy_len, (1 << r) * OSC_CONV_CYCLES + 1);
        check(n_samp, 1 << r);
        // Reads begin after the fall is seen, never on it
        for (k = 0; k < OSC_CHANNELS; k++) begin
            prev[k] = exp_avg(sum[k], r);
            rd(k, v);
            check(v, prev[k]);
        end
    endtask : run_conv
    initial begin
        void'($urandom(37));
        {error_cnt, n_tests, gap, n_samp, busy_len} = '0;
        {start_req, read_req, fix} = 3'h0;
        read_chan_req = 3'h0;
        ratio_req = 3'h0;
        analog_sample = '0;
        rstn = 1'b0;
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 6; i++) run_conv(i); // Codes 000 to 100
        check(start_mismatch_q, 1'b0);
        give_verdict();
    end
    // Watchdog: about twice the expected run
    initial begin
        #240000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule : oversampling_conversion_control_tb

// ===== src/osc_device.sv
// Purpose: Converter-side oversampling control: sample sequencing, averaging, output update
// Assumes: Start and read strobe inputs come from pins and are synchronised here; ratio select and channel are not
// Notes:   Sample values arrive on a user port; each sample takes a fixed conversion time
`timescale 1ns/1ps
// Contract
// - First sample on start edge, rest internal
// - Host lowers start rate at higher ratios
// - Host drives both start inputs together
// - Busy lengthens as ratio grows
// - Reads allowed while busy is high
// - Busy fall loads output data registers
// - Host avoids reading at busy fall
// - Ratio select latched at busy fall
// - Three-bit ratio decode, 111 invalid
module osc_device
    import osc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    osc_link_if.device                link,
    input  wire logic [OSC_CHANNELS*OSC_SAMPLE_W-1:0] analog_sample,
    output logic                      sample_take_q,
    output logic                      start_mismatch_q
);
    logic [1:0]           start_a_sync_q;
    logic [1:0]           start_b_sync_q;
    logic                 start_a_prev_q;
    logic                 start_b_prev_q;
    logic [1:0]           read_sync_q;
    logic                 read_prev_q;
    logic [2:0]           ratio_q;
    osc_state_type        state_q;
    logic [OSC_CNT_W-1:0] conv_cnt_q;
    logic [6:0]           samples_left_q;
    logic                 busy_q;
    logic [OSC_ACC_W-1:0] acc_q [OSC_CHANNELS];
    osc_sample_type       out_reg_q [OSC_CHANNELS];
    osc_sample_type       read_data_q;
    logic                 start_rise;
    logic                 conv_done;

    // Two flops on the start and read strobe inputs before any logic looks at them; ratio select and channel are used directly
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_a_sync_q <= 2'h0;
            start_b_sync_q <= 2'h0;
            read_sync_q    <= 2'h0;
            start_a_prev_q <= 1'b0;
            start_b_prev_q <= 1'b0;
            read_prev_q    <= 1'b0;
        end else begin
            start_a_sync_q <= {start_a_sync_q[0], link.conversion_start_group_a};
            start_b_sync_q <= {start_b_sync_q[0], link.conversion_start_group_b};
            read_sync_q    <= {read_sync_q[0], link.read_strobe};
            start_a_prev_q <= start_a_sync_q[1];
            start_b_prev_q <= start_b_sync_q[1];
            read_prev_q    <= read_sync_q[1];
        end
    end

    // Rising edge of group A starts a conversion; group B is only watched
    assign start_rise = start_a_sync_q[1] && !start_a_prev_q;
    assign conv_done  = (conv_cnt_q == OSC_CNT_W'(OSC_CONV_CYCLES - 1));

    // Flag a split start pair while oversampling; a sticky hint for the user
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_mismatch_q <= 1'b0;
        end else if (ratio_q != OSC_RATIO_NONE
                     && start_a_sync_q[1] != start_b_sync_q[1]
                     && start_a_prev_q != start_b_prev_q) begin
            start_mismatch_q <= 1'b1;
        end
    end

    // Sequencer: first sample on the external edge, remaining ones internally timed
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q        <= OSC_IDLE;
            conv_cnt_q     <= '0;
            samples_left_q <= 7'h0;
            busy_q         <= 1'b0;
            sample_take_q  <= 1'b0;
        end else begin
            sample_take_q <= 1'b0;
            case (state_q)
                OSC_IDLE: begin
                    if (start_rise) begin
                        state_q        <= OSC_CONV;
                        busy_q         <= 1'b1;
                        conv_cnt_q     <= '0;
                        sample_take_q  <= 1'b1;
                        // Sample count 2**ratio sets busy length
                        samples_left_q <= 7'(7'h1 << ratio_q) - 7'h1;
                    end
                end
                OSC_CONV: begin
                    conv_cnt_q <= conv_cnt_q + 1'b1;
                    if (conv_done) begin
                        conv_cnt_q <= '0;
                        if (samples_left_q == 7'h0) begin
                            state_q <= OSC_FINISH;
                        end else begin
                            samples_left_q <= samples_left_q - 7'h1;
                            sample_take_q  <= 1'b1; // Internal sampling signal
                        end
                    end
                end
                OSC_FINISH: begin
                    // Busy falls here, the same edge that loads the outputs
                    busy_q  <= 1'b0;
                    state_q <= OSC_IDLE;
                end
                default: begin
                    state_q <= OSC_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // Ratio captured at busy fall and on each idle cycle; the value held at the start edge governs the next conversion
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ratio_q <= OSC_RATIO_NONE;
        end else if (state_q == OSC_FINISH || (state_q == OSC_IDLE && !busy_q)) begin
            // Invalid code is clamped to the largest ratio rather than wrapping
            if (link.oversample_ratio_select == OSC_RATIO_INVALID) begin
                ratio_q <= OSC_RATIO_MAX;
            end else begin
                ratio_q <= link.oversample_ratio_select;
            end
        end
    end

    // Accumulate each sample; the sum is divided by 2**ratio at the end
    genvar ch;
    generate
        for (ch = 0; ch < OSC_CHANNELS; ch++) begin : g_chan
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    acc_q[ch]     <= '0;
                    out_reg_q[ch] <= '0;
                end else begin
                    if (sample_take_q) begin
                        acc_q[ch] <= acc_q[ch] + OSC_ACC_W'(signed'(
                            analog_sample[ch*OSC_SAMPLE_W +: OSC_SAMPLE_W]));
                    end
                    if (state_q == OSC_FINISH) begin
                        // Arithmetic shift keeps bipolar codes correct
                        out_reg_q[ch] <= OSC_SAMPLE_W'(signed'(acc_q[ch]) >>> ratio_q);
                        acc_q[ch]     <= '0;
                    end
                end
            end
        end
    endgenerate

    // Reads are served in any state, busy or not; a read on the load edge may see old data
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            read_data_q <= '0;
        end else if (read_sync_q[1] && !read_prev_q) begin
            read_data_q <= out_reg_q[link.read_channel];
        end
    end

    assign link.busy      = busy_q;
    assign link.read_data = read_data_q;
endmodule : osc_device

// ===== src/osc_host.sv
// Purpose: Host-side driver: issues paired starts, sets ratio, reads results
// Assumes: Same clock as the device; busy passes two flops here, read data is sampled directly
// Notes:   Reads may overlap busy but are held off around its fall
`timescale 1ns/1ps
module osc_host
    import osc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    osc_link_if.host         link,
    input  wire logic        start_req,
    input  wire logic [2:0]  ratio_req,
    input  wire logic        read_req,
    input  wire logic [2:0]  read_chan_req,
    output logic             start_q,
    output logic [2:0]       ratio_q,
    output logic             read_q,
    output logic [2:0]       read_chan_q,
    output osc_sample_type   read_value_q,
    output logic             read_valid_q,
    output logic             busy_seen_q
);
    logic [1:0] busy_sync_q;
    logic       busy_prev_q;
    logic [1:0] read_ph_q;
    logic       read_late_q;

    // Busy comes from the far end: two flops first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            busy_sync_q <= 2'h0;
            busy_prev_q <= 1'b0;
            busy_seen_q <= 1'b0;
        end else begin
            busy_sync_q <= {busy_sync_q[0], link.busy};
            busy_prev_q <= busy_sync_q[1];
            busy_seen_q <= busy_sync_q[1];
        end
    end

    // One start line drives both groups so they always switch together
    // Start only when idle, which keeps the start rate within the ratio
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            start_q <= 1'b0;
            ratio_q <= OSC_RATIO_NONE;
        end else begin
            start_q <= start_req && !busy_sync_q[1] && !busy_prev_q && !start_q;
            if (ratio_req != OSC_RATIO_INVALID) begin
                ratio_q <= ratio_req; // Never drive the invalid code
            end
        end
    end

    // Read strobe: 2 cycles high, then wait for data; skipped near busy fall
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            read_q       <= 1'b0;
            read_chan_q  <= 3'h0;
            read_ph_q    <= 2'h0;
            read_value_q <= '0;
            read_valid_q <= 1'b0;
            read_late_q  <= 1'b0;
        end else begin
            read_valid_q <= 1'b0;
            case (read_ph_q)
                2'h0: begin
                    if (read_req && !(busy_prev_q && !busy_sync_q[1])) begin
                        read_q      <= 1'b1;
                        read_chan_q <= read_chan_req;
                        read_ph_q   <= 2'h1;
                    end
                end
                2'h1: read_ph_q <= 2'h2;
                2'h2: begin
                    read_q    <= 1'b0;
                    read_ph_q <= 2'h3;
                end
                2'h3: begin
                    // Far end updates its data on the first edge spent in this phase,
                    // so one more cycle passes before the capture
                    if (!read_late_q) begin
                        read_late_q <= 1'b1;
                    end else begin
                        read_late_q  <= 1'b0;
                        read_value_q <= link.read_data;
                        read_valid_q <= 1'b1;
                        read_ph_q    <= 2'h0;
                    end
                end
                default: read_ph_q <= 2'h0;
            endcase
        end
    end

    assign link.conversion_start_group_a = start_q;
    assign link.conversion_start_group_b = start_q;
    assign link.oversample_ratio_select  = ratio_q;
    assign link.read_strobe              = read_q;
    assign link.read_channel             = read_chan_q;
endmodule : osc_host

// ===== src/osc_link_if.sv
// Purpose: Link between host and converter control
// Assumes: Single clock
// Notes:   Both start lines travel separately so the pairing is visible
`timescale 1ns/1ps
interface osc_link_if;
    import osc_pkg::*;
    logic                   conversion_start_group_a;
    logic                   conversion_start_group_b;
    logic [2:0]             oversample_ratio_select;
    logic                   busy;
    logic                   read_strobe;
    logic [2:0]             read_channel;
    osc_sample_type         read_data;

    modport device (
        input  conversion_start_group_a,
        input  conversion_start_group_b,
        input  oversample_ratio_select,
        input  read_strobe,
        input  read_channel,
        output busy,
        output read_data
    );
    modport host (
        output conversion_start_group_a,
        output conversion_start_group_b,
        output oversample_ratio_select,
        output read_strobe,
        output read_channel,
        input  busy,
        input  read_data
    );
endinterface : osc_link_if

// ===== src/osc_pkg.sv
// Purpose: Shared constants and types for the oversampling conversion control pair
// Assumes: One 250 MHz clock shared by both ends
// Notes:   Sample word width and timing counts are plain defaults
package osc_pkg;
    localparam int          OSC_CHANNELS       = 8;
    localparam int          OSC_SAMPLE_W       = 14;
    localparam int          OSC_ACC_W          = OSC_SAMPLE_W + 6;
    localparam int          OSC_CLK_PERIOD_NS  = 4;
    // Time of one internal conversion, in ns
    localparam int          OSC_CONV_TIME_NS   = 4000;
    localparam int          OSC_CONV_CYCLES    = (OSC_CONV_TIME_NS + OSC_CLK_PERIOD_NS - 1)
                                                 / OSC_CLK_PERIOD_NS;
    localparam int          OSC_CNT_W          = 12;
    localparam logic [2:0]  OSC_RATIO_NONE     = 3'h0;
    localparam logic [2:0]  OSC_RATIO_INVALID  = 3'h7;
    localparam logic [2:0]  OSC_RATIO_MAX      = 3'h6;

    typedef logic [OSC_SAMPLE_W-1:0] osc_sample_type;

    typedef enum logic [1:0] {
        OSC_IDLE   = 2'b00,
        OSC_CONV   = 2'b01,
        OSC_FINISH = 2'b10
    } osc_state_type;
endpackage : osc_pkg
